// >>> rtl/xbus_ctrl.sv
// External data bus controller with dual data pointer
//
// Operation
// - Port zero carries low address then data; port two the high address.
// - Address latch strobe pulses while low address is valid on port zero.
// - Active-low read and write strobes drive the external memory.
// - Page access on: pointer moves leave port two showing its register.
// - Index-register moves leave port two showing its register.
// - External RAM select clear: pointer below internal size goes to internal RAM.
// - Page access on: pointer at or above 0800h goes external.
// - External cycle lasts six CPU clock periods, 18 with stretch.
// - Strobe lasts 15 CPU periods with stretch, else 3.
// - External RAM select picks external space, clear picks internal RAM below the internal size.
// - Wide access bit selects 16-bit external moves, clear selects 8-bit.
// - Gating set: latch strobe only on moves; clear: CPU clock over 3.
// - Two data pointers share one address pair; select bit picks one.
// - Incrementing pointer control toggles the select bit.
// - Bus control resets to X000 1101.
// - Size field codes select 256, 512, 1K or 2K internal bytes.
// - Select bit one picks second pointer; it sits at bit zero.
// - Bit one of pointer control reads zero so increments stop there.
`timescale 1ns/1ps
`include "xbus_cfg.svh"
module xbus_ctrl
    import xbus_pkg::*;
(
    input wire logic clk_in, // Oscillator clock, 200 MHz
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic double_speed_mode_in, // One CPU period per clock
    input wire sfr_req_s sfr_in, // Register access from core
    output logic [7:0] sfr_rdata_out, // Register read data
    input wire logic move_valid_in, // Move request, held until done
    input wire move_req_s move_in, // Move request contents
    input wire logic ptr_inc_in, // Increment selected pointer
    output logic move_busy_out, // Move in progress
    output logic move_done_out, // Move finished, one cycle
    output logic [15:0] move_rdata_out, // Read data of last move
    input wire logic [7:0] p0_in, // Port zero pin level
    output logic [7:0] p0_out, // Port zero drive value
    output logic p0_oe_out, // Port zero drive enable
    input wire logic [7:0] p2_in, // Port two pin level
    output logic [7:0] p2_out, // Port two drive value
    output logic p2_oe_out, // Port two drive enable
    output logic ale_out, // Address latch strobe
    output logic rd_n_out, // Read strobe, active low
    output logic wr_n_out // Write strobe, active low
);
    // ****************************************************
    // Register file
    // ****************************************************
    logic [6:0] aux_bus_r;
    logic [7:0] aux_ptr_r;
    logic [15:0] ptr_r [2];
    logic [7:0] port_two_r;
    logic [7:0] psw_r;
    logic [7:0] aux_ptr_inc;
    logic psel;

    assign psel = aux_ptr_r[`XB_BIT_PSEL];
    assign aux_ptr_inc = aux_ptr_r + 8'h01;

    // Register file contents as the core sees them
    function automatic logic [7:0] sfr_view(input logic [7:0] a);
        unique case (a)
            `XB_ADR_AUX_BUS: sfr_view = {1'b0, aux_bus_r};
            `XB_ADR_AUX_PTR: sfr_view = aux_ptr_r;
            `XB_ADR_PTR_LOW: sfr_view = ptr_r[psel][7:0];
            `XB_ADR_PTR_HIGH: sfr_view = ptr_r[psel][15:8];
            `XB_ADR_PORT_TWO: sfr_view = port_two_r;
            `XB_ADR_PSW: sfr_view = psw_r;
            default: sfr_view = 8'h00;
        endcase
    endfunction

    // Internal RAM limit for a size code
    function automatic logic [11:0] internal_expanded_ram_limit(input logic [1:0] code);
        internal_expanded_ram_limit = 12'h100 << code;
    endfunction

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            aux_bus_r <= 7'(`XB_AUX_BUS_RST);
        else if (sfr_in.we && sfr_in.addr == `XB_ADR_AUX_BUS)
            aux_bus_r <= sfr_in.wdata[6:0];
    end

    // Only select and user flag are stored; the carry out of the select
    // bit lands on an unstored bit, so an increment just toggles it
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            aux_ptr_r <= `XB_AUX_PTR_RST;
        else if (sfr_in.inc_ptr_ctl)
            aux_ptr_r <= aux_ptr_inc & 8'h09;
        else if (sfr_in.we && sfr_in.addr == `XB_ADR_AUX_PTR)
            aux_ptr_r <= sfr_in.wdata & 8'h09;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            port_two_r <= `XB_PORT_TWO_RST;
            psw_r <= `XB_PSW_RST;
        end
        else if (sfr_in.we)
        begin
            if (sfr_in.addr == `XB_ADR_PORT_TWO)
                port_two_r <= sfr_in.wdata;
            if (sfr_in.addr == `XB_ADR_PSW)
                psw_r <= sfr_in.wdata;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++)
        begin : g_ptr
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    ptr_r[gp] <= 16'h0000;
                else if (psel == 1'(gp))
                begin
                    if (ptr_inc_in)
                        ptr_r[gp] <= ptr_r[gp] + 16'h0001;
                    else if (sfr_in.we && sfr_in.addr == `XB_ADR_PTR_LOW)
                        ptr_r[gp][7:0] <= sfr_in.wdata;
                    else if (sfr_in.we && sfr_in.addr == `XB_ADR_PTR_HIGH)
                        ptr_r[gp][15:8] <= sfr_in.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            sfr_rdata_out <= 8'h00;
        else
            sfr_rdata_out <= sfr_view(sfr_in.addr);
    end

    // ****************************************************
    // CPU clock and move decode
    // ****************************************************
    logic div_r;
    logic tick;
    logic [1:0] ale_div_r;
    logic gating;
    logic stretch;
    logic page;
    logic wide;
    logic [15:0] move_addr;
    logic go_external;

    assign gating = aux_bus_r[`XB_BIT_GATING];
    assign stretch = aux_bus_r[`XB_BIT_STRETCH];
    assign page = aux_bus_r[`XB_BIT_PAGE];
    assign wide = aux_bus_r[`XB_BIT_WIDE];
    assign tick = double_speed_mode_in | div_r;
    assign move_addr = move_in.via_pointer ? ptr_r[psel]
                                           : {8'h00, move_in.index_addr};

    // Pointer moves past the internal size always go out, so a pointer at
    // 0800h or above reaches the bus whatever the size code says
    assign go_external = aux_bus_r[`XB_BIT_EXTERNAL_RAM_SELECT]
        || (move_in.via_pointer && ({4'h0, internal_expanded_ram_limit(
               aux_bus_r[`XB_BIT_SIZE_HI:`XB_BIT_SIZE_LO])} <= move_addr));

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            div_r <= 1'b0;
        else
            div_r <= ~div_r;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            ale_div_r <= 2'h0;
        else if (tick)
            ale_div_r <= (ale_div_r == `XB_ALE_FREE_DIV - 2'h1) ? 2'h0
                                                           : ale_div_r + 2'h1;
    end

    // ****************************************************
    // Bus sequencer
    // ****************************************************
    bus_state_e state_r;
    logic [3:0] cnt_r;
    logic [3:0] strobe_len;
    logic phase_end;
    logic wr_r;
    logic wide_r;
    logic [15:0] wdata_r;
    logic [7:0] p0_sync;
    logic [7:0] p2_sync;
    logic [7:0] internal_expanded_ram_rdata;
    logic accept;

    assign strobe_len = stretch ? `XB_CPU_STROBE_LONG : `XB_CPU_STROBE;
    assign move_busy_out = state_r != ST_IDLE;
    // Moves start on a CPU period boundary so every phase spans whole periods
    assign accept = state_r == ST_IDLE && move_valid_in && tick;

    always_comb
    begin
        phase_end = 1'b0;
        unique case (state_r)
            ST_ALE: phase_end = tick && cnt_r == `XB_CPU_ALE - 4'h1;
            ST_SETUP: phase_end = tick && cnt_r == `XB_CPU_SETUP - 4'h1;
            ST_STROBE: phase_end = tick && cnt_r == strobe_len - 4'h1;
            ST_HOLD: phase_end = tick && cnt_r == `XB_CPU_HOLD - 4'h1;
            ST_IDLE, ST_INTERNAL: phase_end = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_r <= ST_IDLE;
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (accept)
                        state_r <= go_external ? ST_ALE : ST_INTERNAL;
                ST_ALE:
                    if (phase_end)
                        state_r <= ST_SETUP;
                ST_SETUP:
                    if (phase_end)
                        state_r <= ST_STROBE;
                ST_STROBE:
                    if (phase_end)
                        state_r <= ST_HOLD;
                ST_HOLD:
                    if (phase_end)
                        state_r <= ST_IDLE;
                ST_INTERNAL:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in || state_r == ST_IDLE || phase_end)
            cnt_r <= 4'h0;
        else if (tick)
            cnt_r <= cnt_r + 4'h1;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_r <= 1'b0;
            wide_r <= 1'b0;
            wdata_r <= 16'h0000;
        end
        else if (accept)
        begin
            wr_r <= move_in.write;
            wide_r <= wide;
            wdata_r <= move_in.wdata;
        end
    end

    // ****************************************************
    // Pins
    // ****************************************************
    // Port zero: address during latch and setup, write data while the
    // write strobe is low, released for the memory during a read
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            p0_out <= 8'h00;
            p0_oe_out <= 1'b0;
        end
        else if (accept && go_external)
        begin
            p0_out <= move_addr[7:0];
            p0_oe_out <= 1'b1;
        end
        else if (state_r == ST_SETUP && phase_end)
        begin
            p0_out <= wr_r ? wdata_r[7:0] : 8'h00;
            p0_oe_out <= wr_r;
        end
        else if (state_r == ST_HOLD && phase_end)
            p0_oe_out <= 1'b0;
    end

    // Port two: high address unless page access or an index move leaves
    // the port register on it; wide moves carry the high data byte
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            p2_out <= `XB_PORT_TWO_RST;
            p2_oe_out <= 1'b1;
        end
        else if (accept && go_external)
        begin
            p2_out <= (move_in.via_pointer && !page) ? move_addr[15:8]
                                                     : port_two_r;
            p2_oe_out <= 1'b1;
        end
        else if (state_r == ST_SETUP && phase_end && wide_r)
        begin
            p2_out <= wdata_r[15:8];
            p2_oe_out <= wr_r;
        end
        else if (state_r == ST_IDLE)
        begin
            p2_out <= port_two_r;
            p2_oe_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            ale_out <= 1'b0;
        else if (accept && go_external)
            ale_out <= 1'b1;
        else if (move_busy_out)
            ale_out <= state_r == ST_ALE && !phase_end;
        else
            ale_out <= !gating && ale_div_r == 2'h0;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
        end
        else if (state_r == ST_SETUP && phase_end)
        begin
            rd_n_out <= wr_r;
            wr_n_out <= !wr_r;
        end
        else if (state_r == ST_STROBE && phase_end)
        begin
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
        end
    end

    xbus_sync3 #(.W(16)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pin_in({p2_in, p0_in}),
        .level_out({p2_sync, p0_sync})
    );

    xbus_internal_expanded_ram u_internal_expanded_ram (
        .clk_in(clk_in),
        .we_in(accept && !go_external && move_in.write),
        .addr_in(move_addr[10:0]),
        .wdata_in(move_in.wdata[7:0]),
        .rdata_out(internal_expanded_ram_rdata)
    );

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            move_rdata_out <= 16'h0000;
        // Taken at hold end: the pin filter lags the strobe by three edges
        else if (state_r == ST_HOLD && phase_end && !wr_r)
            move_rdata_out <= {wide_r ? p2_sync : 8'h00, p0_sync};
        else if (state_r == ST_INTERNAL && !wr_r)
            move_rdata_out <= {8'h00, internal_expanded_ram_rdata};
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            move_done_out <= 1'b0;
        else
            move_done_out <= (state_r == ST_HOLD && phase_end)
                             || state_r == ST_INTERNAL;
    end

    // ****************************************************
    // Checks
    // ****************************************************
    logic [5:0] low_cnt_r;
    logic [6:0] cyc_cnt_r;
    logic [6:0] per;

    assign per = double_speed_mode_in ? 7'h01 : 7'h02;

    always_ff @(posedge clk_in)
    begin
        if (rst_in || (rd_n_out && wr_n_out))
            low_cnt_r <= 6'h00;
        else
            low_cnt_r <= low_cnt_r + 6'h01;
        if (rst_in || !(move_busy_out && state_r != ST_INTERNAL))
            cyc_cnt_r <= 7'h00;
        else
            cyc_cnt_r <= cyc_cnt_r + 7'h01;
    end

    property p_strobe_len;
        @(posedge clk_in) disable iff (rst_in)
        $rose(rd_n_out & wr_n_out) |->
            {1'b0, low_cnt_r} == {3'h0, strobe_len} * per;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe width wrong");

    property p_cycle_len;
        @(posedge clk_in) disable iff (rst_in)
        (state_r == ST_HOLD && phase_end && !stretch) |->
            cyc_cnt_r + 7'h01 == {2'h0, `XB_CPU_CYCLE} * per;
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("bus cycle length wrong");

    property p_ale_addr;
        @(posedge clk_in) disable iff (rst_in)
        state_r == ST_ALE |-> ale_out && p0_oe_out && rd_n_out && wr_n_out;
    endproperty
    a_ale_addr: assert property (p_ale_addr)
        else $error("latch strobe without address");

    property p_one_strobe;
        @(posedge clk_in) disable iff (rst_in)
        !(!rd_n_out && !wr_n_out);
    endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("both strobes low");

    property p_bus_dir;
        @(posedge clk_in) disable iff (rst_in)
        (!rd_n_out |-> !p0_oe_out) and (!wr_n_out |-> p0_oe_out);
    endproperty
    a_bus_dir: assert property (p_bus_dir)
        else $error("port zero direction wrong in strobe");

    property p_page;
        @(posedge clk_in) disable iff (rst_in)
        (accept && go_external && (page || !move_in.via_pointer))
            |=> p2_out == $past(port_two_r);
    endproperty
    a_page: assert property (p_page)
        else $error("port two lost its register value");

    property p_reset_val;
        @(posedge clk_in) disable iff (rst_in)
        $past(rst_in) |-> aux_bus_r == 7'h0d && aux_ptr_r == 8'h00;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("bus control reset value wrong");

    property p_toggle;
        @(posedge clk_in) disable iff (rst_in)
        sfr_in.inc_ptr_ctl |=> psel != $past(psel)
            && aux_ptr_r[`XB_BIT_FLAG] == $past(aux_ptr_r[`XB_BIT_FLAG]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pointer select did not toggle");

    property p_free_ale;
        @(posedge clk_in) disable iff (rst_in)
        ($rose(ale_out) && !gating && !move_busy_out && double_speed_mode_in
         && !move_valid_in) |=> !ale_out [*2];
    endproperty
    a_free_ale: assert property (p_free_ale)
        else $error("free latch strobe rate wrong");

    c_read: cover property (@(posedge clk_in) $rose(rd_n_out));
    c_write: cover property (@(posedge clk_in) $rose(wr_n_out));
    c_internal: cover property (@(posedge clk_in) state_r == ST_INTERNAL);
    c_stretch: cover property (@(posedge clk_in) !rd_n_out && stretch);
endmodule

// >>> inc/xbus_cfg.svh
// Constants of the external data bus controller
`ifndef XBUS_CFG_SVH
`define XBUS_CFG_SVH
`define XB_ADR_PTR_LOW 8'h84
`define XB_ADR_PTR_HIGH 8'h83
`define XB_ADR_PORT_TWO 8'ha0
`define XB_ADR_AUX_BUS 8'h8e
`define XB_ADR_AUX_PTR 8'ha2
`define XB_ADR_PSW 8'hd0
`define XB_AUX_BUS_RST 8'h0d
`define XB_AUX_PTR_RST 8'h00
`define XB_PSW_RST 8'h00
`define XB_PORT_TWO_RST 8'hff
`define XB_BIT_WIDE 6
`define XB_BIT_STRETCH 5
`define XB_BIT_PAGE 4
`define XB_BIT_SIZE_HI 3
`define XB_BIT_SIZE_LO 2
`define XB_BIT_EXTERNAL_RAM_SELECT 1
`define XB_BIT_GATING 0
`define XB_BIT_FLAG 3
`define XB_BIT_PSEL 0
`define XB_CPU_ALE 4'h1
`define XB_CPU_SETUP 4'h1
`define XB_CPU_STROBE 4'h3
`define XB_CPU_STROBE_LONG 4'hf
`define XB_CPU_HOLD 4'h1
`define XB_CPU_CYCLE 5'h06
`define XB_ALE_FREE_DIV 2'h3
`define XB_INTERNAL_EXPANDED_RAM_DEPTH 2048
`endif

// >>> inc/xbus_pkg.sv
// Types of the external data bus controller
package xbus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ALE, ST_SETUP, ST_STROBE, ST_HOLD, ST_INTERNAL
    } bus_state_e;

    typedef struct packed {
        logic write;
        logic via_pointer;
        logic [7:0] index_addr;
        logic [15:0] wdata;
    } move_req_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic inc_ptr_ctl;
    } sfr_req_s;
endpackage

// >>> rtl/xbus_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module xbus_sync3 #(
    parameter int W = 8
) (
    input wire logic clk_in, // Core clock
    input wire logic rst_in, // Synchronous reset
    input wire logic [W-1:0] pin_in, // Asynchronous pin level
    output logic [W-1:0] level_out // Filtered level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] held_r;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit changes only once two stable samples agree
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    held_r[i] <= 1'b0;
                else if (s2_r[i] == s3_r[i])
                    held_r[i] <= s3_r[i];
            end
            assign level_out[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : held_r[i];
        end
    endgenerate
endmodule

// >>> rtl/xbus_internal_expanded_ram.sv
// Internal expanded RAM built from flip-flops
`timescale 1ns/1ps
`include "xbus_cfg.svh"
module xbus_internal_expanded_ram (
    input wire logic clk_in, // Core clock
    input wire logic we_in, // Write strobe
    input wire logic [10:0] addr_in, // Byte index
    input wire logic [7:0] wdata_in, // Write byte
    output logic [7:0] rdata_out // Registered read byte
);
    logic [7:0] mem_r [`XB_INTERNAL_EXPANDED_RAM_DEPTH];

    // No reset: contents are undefined after power-up anyway
    always_ff @(posedge clk_in)
    begin
        if (we_in)
            mem_r[addr_in] <= wdata_in;
        rdata_out <= mem_r[addr_in];
    end
endmodule

// >>> verif/xbus_mem.sv
// Behavioural external data memory on the multiplexed bus
`timescale 1ns/1ps
module xbus_mem (
    input wire logic clk_in, // Core clock
    input wire logic [7:0] p0_drv_in, // Port zero drive value
    input wire logic p0_oe_in, // Port zero drive enable
    input wire logic [7:0] p2_in, // Port two level
    input wire logic ale_in, // Address latch strobe
    input wire logic rd_n_in, // Read strobe
    input wire logic wr_n_in, // Write strobe
    output logic [7:0] pin_out // Resolved port zero level
);
    // ****************
    // Memory and latch
    // ****************
    logic [7:0] mem [logic [15:0]];
    logic [15:0] adr_r;
    logic [7:0] last_r;

    always @(negedge ale_in)
        adr_r = {p2_in, p0_drv_in};

    // Stored on each clock of a low write strobe; an edge-triggered store
    // would also fire on the undefined-to-high step of the strobe at reset
    always @(posedge clk_in)
        if (wr_n_in === 1'b0)
            mem[adr_r] = pin_out;

    // Released bus flips each cycle so stale data never looks valid
    always @(posedge clk_in)
        last_r <= pin_out;

    always @*
        if (p0_oe_in)
            pin_out = p0_drv_in;
        else if (!rd_n_in)
            pin_out = mem.exists(adr_r) ? mem[adr_r] : 8'h00;
        else
            pin_out = ~last_r;
endmodule

// >>> verif/test_xbus_ctrl.sv
// Self-checking testbench of the external data bus controller
`timescale 1ns/1ps
`include "xbus_cfg.svh"
module test_xbus_ctrl
    import xbus_pkg::*;
;
    // *****
    // Setup
    // *****
    logic clk_in, rst_in, x2, mv, pinc, mon;
    logic p0_oe, p2_oe, ale, rd_n, wr_n, done, busy;
    sfr_req_s sfr;
    move_req_s mreq;
    logic [7:0] srd, p0_o, p2_o, p0_pin, p2_pin, pw, n;
    logic [15:0] mrd, pa, n_low, n_ale, n_busy;
    int n_errors, n_checks, cyc;

    xbus_ctrl i_xbus_ctrl (.clk_in(clk_in), .rst_in(rst_in),
        .double_speed_mode_in(x2), .sfr_in(sfr), .sfr_rdata_out(srd),
        .move_valid_in(mv), .move_in(mreq), .ptr_inc_in(pinc),
        .move_busy_out(busy), .move_done_out(done), .move_rdata_out(mrd),
        .p0_in(p0_pin), .p0_out(p0_o), .p0_oe_out(p0_oe),
        .p2_in(p2_pin), .p2_out(p2_o), .p2_oe_out(p2_oe),
        .ale_out(ale), .rd_n_out(rd_n), .wr_n_out(wr_n));
    xbus_mem i_xbus_mem (.clk_in(clk_in), .p0_drv_in(p0_o),
        .p0_oe_in(p0_oe), .p2_in(p2_pin), .ale_in(ale),
        .rd_n_in(rd_n), .wr_n_in(wr_n), .pin_out(p0_pin));
    assign p2_pin = p2_oe ? p2_o : 8'hff;

    initial
    begin
        clk_in = 0;
        forever #2.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    // Sampled at the falling edge, where outputs have settled
    always @(negedge clk_in)
        if (mon)
        begin
            n_low += (rd_n === 1'b0 || wr_n === 1'b0);
            n_ale += (ale === 1'b1);
            n_busy += (busy === 1'b1);
            if (ale)
                pa = {p2_o, p0_o};
            if (!wr_n)
                pw = p2_o;
        end

    // *****
    // Tasks
    // *****
    task chk(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, d, input logic inc);
        @(negedge clk_in);
        sfr = '{a, d, !inc, inc};
        @(negedge clk_in);
        sfr.we = 0;
        sfr.inc_ptr_ctl = 0;
    endtask

    task rd(input logic [7:0] a, e);
        @(negedge clk_in);
        sfr.addr = a;
        @(posedge clk_in);
        #1;
        chk("register", {8'h00, srd}, {8'h00, e});
    endtask

    task mv_do(input logic w, p, input logic [7:0] ix, input logic [15:0] d);
        @(negedge clk_in);
        mreq = '{w, p, ix, d};
        mv = 1;
        n_low = 0;
        n_ale = 0;
        n_busy = 0;
        mon = 1;
        repeat (200)
        begin
            @(posedge clk_in);
            #1;
            if (done === 1'b1)
                break;
        end
        @(negedge clk_in);
        mv = 0;
        mon = 0;
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // *********
    // Sequences
    // *********
    initial
    begin
        rst_in = 1;
        x2 = 1;
        mv = 0;
        pinc = 0;
        mon = 0;
        sfr = '0;
        mreq = '0;
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        repeat (12) @(negedge clk_in);
        rst_in = 0;
        rd(`XB_ADR_AUX_BUS, `XB_AUX_BUS_RST);
        rd(`XB_ADR_PORT_TWO, `XB_PORT_TWO_RST);
        rd(8'h55, 8'h00);
        wr(`XB_ADR_PTR_HIGH, 8'h12, 0);
        wr(`XB_ADR_PTR_LOW, 8'h34, 0);
        wr(`XB_ADR_AUX_PTR, 8'h08, 0);
        wr(`XB_ADR_AUX_PTR, 8'h00, 1);
        rd(`XB_ADR_AUX_PTR, 8'h09);
        wr(`XB_ADR_PTR_HIGH, 8'h03, 0);
        wr(`XB_ADR_PTR_LOW, 8'h00, 0);
        wr(`XB_ADR_AUX_PTR, 8'h00, 1);
        rd(`XB_ADR_PTR_HIGH, 8'h12);
        mv_do(1, 1, 8'h00, 16'h005a);
        chk("strobe", n_low, 16'd3);
        chk("latch", n_ale, 16'd1);
        chk("address", pa, 16'h1234);
        chk("busy", n_busy, 16'd6);
        chk("memory", {8'h00, i_xbus_mem.mem[16'h1234]}, 16'h005a);
        mv_do(0, 1, 8'h00, 16'h0000);
        chk("read", mrd, 16'h005a);
        wr(`XB_ADR_AUX_PTR, 8'h00, 1);
        mv_do(1, 1, 8'h00, 16'h00c3);
        for (int s = 0; s < 4; s++)
        begin
            wr(`XB_ADR_AUX_BUS, {4'h0, s[1:0], 2'b01}, 0);
            mv_do(0, 1, 8'h00, 16'h0000);
            chk("latch", n_ale, 16'(s < 2));
            chk("read", mrd, s < 2 ? 16'h0000 : 16'h00c3);
        end
        wr(`XB_ADR_PORT_TWO, 8'h3c, 0);
        wr(`XB_ADR_AUX_BUS, 8'h1d, 0);
        wr(`XB_ADR_AUX_PTR, 8'h00, 1);
        mv_do(1, 1, 8'h00, 16'h0077);
        chk("address", pa, 16'h3c34);
        wr(`XB_ADR_AUX_BUS, 8'h0f, 0);
        mv_do(1, 0, 8'h44, 16'h0099);
        chk("address", pa, 16'h3c44);
        wr(`XB_ADR_AUX_BUS, 8'h0d, 0);
        mv_do(1, 0, 8'h45, 16'h0011);
        chk("latch", n_ale, 16'd0);
        wr(`XB_ADR_AUX_BUS, 8'h4f, 0);
        mv_do(1, 0, 8'h46, 16'ha55a);
        chk("high data", {8'h00, pw}, 16'h00a5);
        wr(`XB_ADR_AUX_BUS, 8'h2f, 0);
        mv_do(0, 0, 8'h44, 16'h0000);
        chk("strobe", n_low, 16'd15);
        chk("read", mrd, 16'h0099);
        x2 = 0;
        wr(`XB_ADR_AUX_BUS, 8'h0f, 0);
        mv_do(0, 0, 8'h44, 16'h0000);
        chk("strobe", n_low, 16'd6);
        chk("latch", n_ale, 16'd2);
        chk("busy", n_busy, 16'd12);
        chk("read", mrd, 16'h0099);
        x2 = 1;
        for (int g = 0; g < 2; g++)
        begin
            wr(`XB_ADR_AUX_BUS, {7'h07, g[0]}, 0);
            repeat (3) @(negedge clk_in);
            n = 0;
            repeat (12) @(negedge clk_in) n += ale;
            chk("free latch", {8'h00, n}, g ? 16'd0 : 16'd4);
        end
        wr(`XB_ADR_AUX_PTR, 8'h00, 1);
        wr(`XB_ADR_PTR_LOW, 8'hff, 0);
        @(negedge clk_in);
        pinc = 1;
        @(negedge clk_in);
        pinc = 0;
        rd(`XB_ADR_PTR_HIGH, 8'h04);
        end_of_test();
    end
endmodule
